// ==== verif/fsm_peer_model.sv ====
`timescale 1ns/10ps
module fsm_peer_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic fault_i,
  output logic prev_done_o,
  output logic next_done_o,
  output logic bus_o
);
  logic [2:0] dly_reg;
  // neighbours lag the shared enable, so chain waits are exercised
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_reg <= 3'h0;
      prev_done_o <= 1'b0;
      next_done_o <= 1'b0;
    end else if (prev_done_o == enable_i) begin
      dly_reg <= 3'h0;
    end else begin
      dly_reg <= dly_reg + 3'h1;
      if (dly_reg == 3'h4) begin
        prev_done_o <= enable_i;
        next_done_o <= enable_i;
      end
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_o <= 1'b0;
    end else begin
      bus_o <= fault_i;
    end
  end
endmodule : fsm_peer_model

// ==== verif/fsm_sva.sv ====
`timescale 1ns/10ps
module fsm_sva
  import fsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic enable_i,
  input wire logic group_bus_o,
  input wire logic group_bus_oe_o,
  input wire logic power_on_o,
  input wire logic seq_done_o,
  input wire logic phase_start_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rdy;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1;
    pready_o |=> !pready_o;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  property p_rdata;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside access");
  property p_map;
    pready_o |-> pslverr_o == (paddr_i > FSM_GRANT_OFS || paddr_i[1:0] != 2'h0);
  endproperty
  a_map: assert property (p_map) else $error("slave error mismatch");
  property p_seq;
    seq_done_o |-> power_on_o;
  endproperty
  a_seq: assert property (p_seq) else $error("sequenced without output");
  property p_bus;
    group_bus_o |-> group_bus_oe_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus level without enable");
  property p_bcast;
    $rose(group_bus_oe_o) |-> ##[0:2] !power_on_o;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast without shutdown");
  property p_en;
    $rose(seq_done_o) |-> $past(enable_i);
  endproperty
  a_en: assert property (p_en) else $error("power up without enable");
  property p_phase;
    phase_start_o |=> !phase_start_o;
  endproperty
  a_phase: assert property (p_phase) else $error("phase mark too long");
endmodule : fsm_sva
bind fault_sequence_manager fsm_sva i_fsm_sva (.clk_i, .nrst_i, .psel_i, .penable_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .enable_i, .group_bus_o, .group_bus_oe_o,
  .power_on_o, .seq_done_o, .phase_start_o);

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import fsm_pkg::*;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, enable_i, sync_clk_i, sw_cycle_i;
  logic peak_over_i, group_bus_i, group_bus_o, group_bus_oe_o, prev_done_i, next_done_i;
  logic pready_o, pslverr_o, power_on_o, seq_done_o, phase_start_o, peer_bus, peer_fault;
  logic rd_e;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_v;
  logic [15:0] peak_limit_o, r16;
  logic [15:0] tel [8];
  integer seed = 32'h83327f86;
  int num_errors = 0;
  int checked = 0;
  int bc_seen = 0;
  int ph_seen = 0;
  int ph0;
  fault_sequence_manager i_fault_sequence_manager (
    .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .enable_i, .sync_clk_i, .sw_cycle_i, .peak_over_i,
    .vin_i(tel[0]), .vout_i(tel[1]), .iout_i(tel[2]), .temp_int_i(tel[3]),
    .temp_ext_i(tel[4]), .duty_i(tel[5]), .freq_i(tel[6]), .vmon_i(tel[7]),
    .group_bus_i, .group_bus_o, .group_bus_oe_o, .prev_done_i, .next_done_i,
    .power_on_o, .seq_done_o, .phase_start_o, .peak_limit_o);
  fsm_peer_model i_fsm_peer_model (.clk_i, .nrst_i, .enable_i, .fault_i(peer_fault),
    .prev_done_o(prev_done_i), .next_done_o(next_done_i), .bus_o(peer_bus));
  // wired-or fault line, idle low
  assign group_bus_i = (group_bus_oe_o & group_bus_o) | peer_bus;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    forever begin
      repeat (8) @(posedge clk_i);
      sync_clk_i <= ~sync_clk_i;
    end
  end
  always @(negedge clk_i) begin
    if (group_bus_oe_o === 1'b1 && group_bus_o === 1'b1) bc_seen++;
    if (phase_start_o === 1'b1) ph_seen++;
  end
  task final_report;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // no wait bound here: the watchdog cuts a hung slave short
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd_v = prdata_o;
    rd_e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask : rdc
  task wt(input logic s, input logic v);
    int n;
    n = 0;
    @(negedge clk_i);
    while ((s ? seq_done_o : power_on_o) !== v && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0, s ? seq_done_o : power_on_o}, {31'h0, v});
    @(posedge clk_i);
  endtask : wt
  function automatic logic [15:0] exp_peak(input logic [15:0] lim, input logic [15:0] vin,
    input logic [15:0] vset, input logic [15:0] f);
    exp_peak = lim + 16'((((32'(vin) - 32'(vset)) * 32'(vset)) / (32'(vin) * 32'(f))) >> 1);
  endfunction : exp_peak
  task sw(input int k);
    repeat (k) begin
      @(posedge clk_i);
      sw_cycle_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sw_cycle_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : sw
  initial begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    final_report;
  end
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, enable_i, sync_clk_i, sw_cycle_i} = 7'h0;
    {peak_over_i, peer_fault, paddr_i, pwdata_i} = 42'h0;
    for (int i = 0; i < 8; i++) tel[i] = 16'h0019;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc(FSM_OT_LIMIT_OFS, 32'h7d);
    rdc(FSM_OC_LIMIT_OFS, 32'hffff);
    rdc(8'h54, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      r16 = 16'($random(seed));
      tel[i] <= r16;
      rdc(FSM_VIN_OFS + 8'(i * 4), {16'h0, r16});
    end
    tel[3] <= 16'h0019;
    tel[0] <= 16'h0064;
    tel[2] <= 16'h0019;
    tel[6] <= 16'h0001;
    apb(1'b1, FSM_OC_LIMIT_OFS, 32'h1000);
    apb(1'b1, FSM_VOUT_SET_OFS, 32'h0028);
    apb(1'b1, FSM_CTRL_OFS, 32'h1);
    apb(1'b1, FSM_SEQ_OFS, 32'h0c61);
    rdc(FSM_SEQ_OFS, 32'h0c61);
    r16 = exp_peak(16'h1000, 16'h0064, 16'h0028, 16'h0001);
    chk({16'h0, peak_limit_o}, {16'h0, r16});
    enable_i <= 1'b1;
    wt(1'b1, 1'b1);
    // power down waits for the next device in the chain
    enable_i <= 1'b0;
    wt(1'b1, 1'b0);
    chk({31'h0, power_on_o}, 32'h1);
    wt(1'b0, 1'b0);
    enable_i <= 1'b1;
    wt(1'b1, 1'b1);
    // a broken run of four must not count
    peak_over_i <= 1'b1;
    sw(4);
    peak_over_i <= 1'b0;
    sw(1);
    peak_over_i <= 1'b1;
    sw(4);
    wt(1'b0, 1'b1);
    sw(1);
    wt(1'b0, 1'b0);
    peak_over_i <= 1'b0;
    chk({31'h0, bc_seen != 0}, 32'h1);
    apb(1'b0, FSM_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h1, 32'h1);
    rdc(FSM_SNAP_IOUT_OFS, {16'h0, tel[2]});
    repeat (50) @(posedge clk_i);
    wt(1'b0, 1'b0);
    enable_i <= 1'b0;
    apb(1'b1, FSM_CTRL_OFS, 32'h1);
    repeat (20) @(posedge clk_i);
    apb(1'b0, FSM_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h1f, 32'h0);
    enable_i <= 1'b1;
    wt(1'b1, 1'b1);
    apb(1'b1, FSM_RETRY_OFS, 32'h00001002);
    tel[3] <= 16'h007e;
    wt(1'b0, 1'b0);
    // inside the hysteresis band the device must stay off
    tel[3] <= 16'h0070;
    repeat (100) @(posedge clk_i);
    wt(1'b0, 1'b0);
    tel[3] <= 16'h006d;
    wt(1'b1, 1'b1);
    apb(1'b0, FSM_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h4, 32'h0);
    peer_fault <= 1'b1;
    wt(1'b0, 1'b0);
    peer_fault <= 1'b0;
    wt(1'b1, 1'b1);
    apb(1'b1, FSM_RETRY_OFS, 32'h00001003);
    tel[2] <= 16'h1001;
    wt(1'b0, 1'b0);
    apb(1'b0, FSM_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h2, 32'h2);
    tel[2] <= 16'h0019;
    wt(1'b1, 1'b1);
    apb(1'b1, FSM_CTRL_OFS, 32'h4);
    repeat (12) @(posedge clk_i);
    apb(1'b0, FSM_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h10, 32'h10);
    apb(1'b1, FSM_GRANT_OFS, 32'h1);
    apb(1'b1, FSM_CTRL_OFS, 32'h2);
    repeat (12) @(posedge clk_i);
    apb(1'b1, FSM_OT_LIMIT_OFS, 32'h80);
    apb(1'b1, FSM_CTRL_OFS, 32'h4);
    repeat (12) @(posedge clk_i);
    rdc(FSM_OT_LIMIT_OFS, 32'h7d);
    ph0 = ph_seen;
    repeat (160) @(posedge clk_i);
    chk(ph_seen - ph0, 32'd10);
    final_report;
  end
endmodule : testbench

// ==== verilog/fault_sequence_manager.sv ====
`timescale 1ns/10ps
// How it works
// - five consecutive peak overcurrent cycles force shutdown
// - peak threshold from vin, frequency, setpoint ripple
// - programmable average overcurrent limit raises fault
// - overcurrent defaults to no retry, programmable
// - over temperature above limit, default 125, shuts down
// - over temperature defaults to no retry
// - retry waits delay, restarts 15 below limit
// - still hot: wait delay and check again
// - phase offset in 22.5 degree steps
// - phase offset counts on shared sync clock
// - chain order from previous and next device
// - shared enable low starts ordered power down
// - fault shuts output; own (not group) fault broadcasts on group bus
// - honoured group fault shuts down, then resequences
// - telemetry readable over the register bus
// - fault snapshot of measurements and status captured
// - stored user values never loaded at initialisation: reset clears the store tag
// - store command writes settings to nonvolatile memory
// - restore only from levels granted to user
module fault_sequence_manager
  import fsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic enable_i,
  input wire logic sync_clk_i,
  input wire logic sw_cycle_i,
  input wire logic peak_over_i,
  input wire logic [15:0] vin_i,
  input wire logic [15:0] vout_i,
  input wire logic [15:0] iout_i,
  input wire logic [15:0] temp_int_i,
  input wire logic [15:0] temp_ext_i,
  input wire logic [15:0] duty_i,
  input wire logic [15:0] freq_i,
  input wire logic [15:0] vmon_i,
  input wire logic group_bus_i,
  output logic group_bus_o,
  output logic group_bus_oe_o,
  input wire logic prev_done_i,
  input wire logic next_done_i,
  output logic power_on_o,
  output logic seq_done_o,
  output logic phase_start_o,
  output logic [15:0] peak_limit_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] en_s, sy_s, cy_s, pk_s, gb_s, pd_s, nd_s;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_s <= 2'h0;
      sy_s <= 2'h0;
      cy_s <= 2'h0;
      pk_s <= 2'h0;
      gb_s <= 2'h0;
      pd_s <= 2'h0;
      nd_s <= 2'h0;
    end else begin
      en_s <= {en_s[0], enable_i};
      sy_s <= {sy_s[0], sync_clk_i};
      cy_s <= {cy_s[0], sw_cycle_i};
      pk_s <= {pk_s[0], peak_over_i};
      gb_s <= {gb_s[0], group_bus_i};
      pd_s <= {pd_s[0], prev_done_i};
      nd_s <= {nd_s[0], next_done_i};
    end
  end
  logic sy_d, cy_d;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sy_d <= 1'b0;
      cy_d <= 1'b0;
    end else begin
      sy_d <= sy_s[1];
      cy_d <= cy_s[1];
    end
  end
  wire sync_rise = sy_s[1] & ~sy_d;
  wire cyc_rise = cy_s[1] & ~cy_d;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0] oc_limit_reg, ot_limit_reg, vout_set_reg;
  logic [31:0] retry_reg, seq_reg;
  logic [3:0] phase_reg;
  logic [1:0] grant_reg;
  logic [FSM_ST_FLAGS-1:0] status_reg;
  logic [31:0] snap_stat_reg, snap_iout_reg, snap_temp_reg, snap_vout_reg;
  fsm_state_t state_reg, state_next;

  wire setup = psel_i & ~penable_i;
  wire wr_acc = psel_i & penable_i & pwrite_i & pready_o;
  wire clear_cmd = wr_acc && paddr_i == FSM_CTRL_OFS && pwdata_i[FSM_CTRL_CLEAR_BIT];
  wire store_cmd = wr_acc && paddr_i == FSM_CTRL_OFS && pwdata_i[FSM_CTRL_STORE_BIT];
  wire restore_cmd = wr_acc && paddr_i == FSM_CTRL_OFS && pwdata_i[FSM_CTRL_RESTORE_BIT];
  wire restore_ok = restore_cmd && grant_reg == FSM_LEVEL_USER;

  // nonvolatile copy: word index walks through the settings
  logic nv_busy_reg, nv_load_reg;
  logic [2:0] nv_idx_reg;
  logic [31:0] nv_rdata;
  logic nv_valid;
  logic [31:0] nv_wdata;
  always_comb begin
    nv_wdata = 32'h0000_0000;
    unique case (nv_idx_reg)
      3'h0: nv_wdata = {16'h0000, oc_limit_reg};
      3'h1: nv_wdata = {16'h0000, ot_limit_reg};
      3'h2: nv_wdata = retry_reg;
      3'h3: nv_wdata = {28'h0000000, phase_reg};
      3'h4: nv_wdata = seq_reg;
      3'h5: nv_wdata = {16'h0000, vout_set_reg};
      default: nv_wdata = 32'h0000_0000;
    endcase
  end
  wire nv_wr = nv_busy_reg & ~nv_load_reg;

  fsm_nvm u_nvm (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(nv_wr),
    .addr_i(nv_idx_reg),
    .wdata_i(nv_wdata),
    .rdata_o(nv_rdata),
    .valid_o(nv_valid)
  );

  wire nv_last = nv_idx_reg == 3'h7;
  wire init_go = state_reg == FSM_ST_INIT && !nv_busy_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_busy_reg <= 1'b0;
      nv_load_reg <= 1'b0;
      nv_idx_reg <= 3'h0;
    end else if (nv_busy_reg) begin
      nv_idx_reg <= nv_idx_reg + 3'h1;
      nv_busy_reg <= !nv_last;
    end else if (init_go && nv_valid) begin
      nv_busy_reg <= 1'b1;
      nv_load_reg <= 1'b1;
    end else if (store_cmd) begin
      nv_busy_reg <= 1'b1;
      nv_load_reg <= 1'b0;
    end else if (restore_ok && nv_valid) begin
      nv_busy_reg <= 1'b1;
      nv_load_reg <= 1'b1;
    end
  end
  wire ld = nv_busy_reg & nv_load_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_limit_reg <= FSM_OC_LIMIT_RST;
      ot_limit_reg <= FSM_OT_LIMIT_RST;
      retry_reg <= 32'h0000_0000;
      phase_reg <= 4'h0;
      seq_reg <= 32'h0000_0000;
      vout_set_reg <= 16'h0000;
    end else if (ld) begin
      unique case (nv_idx_reg)
        3'h0: oc_limit_reg <= nv_rdata[15:0];
        3'h1: ot_limit_reg <= nv_rdata[15:0];
        3'h2: retry_reg <= nv_rdata;
        3'h3: phase_reg <= nv_rdata[3:0];
        3'h4: seq_reg <= nv_rdata;
        3'h5: vout_set_reg <= nv_rdata[15:0];
        default: ;
      endcase
    end else if (wr_acc) begin
      unique case (paddr_i)
        FSM_OC_LIMIT_OFS: oc_limit_reg <= pwdata_i[15:0];
        FSM_OT_LIMIT_OFS: ot_limit_reg <= pwdata_i[15:0];
        FSM_RETRY_OFS: retry_reg <= pwdata_i;
        FSM_PHASE_OFS: phase_reg <= pwdata_i[3:0];
        FSM_SEQ_OFS: seq_reg <= pwdata_i;
        FSM_VOUT_SET_OFS: vout_set_reg <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // access level granted to the user; factory-only until raised
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      grant_reg <= FSM_LEVEL_FACTORY;
    end else if (wr_acc && paddr_i == FSM_GRANT_OFS) begin
      grant_reg <= pwdata_i[1:0];
    end
  end

  // ----------------------------------------
  // peak threshold and fault detection
  // ----------------------------------------
  // ripple ~ (vin - vout) * vout / (vin * f); computed with a full divide, then halved before it is added to the limit
  logic [15:0] ripple;
  always_comb begin
    ripple = 16'h0000;
    if (vin_i > vout_set_reg && freq_i != 16'h0000) begin
      ripple = 16'((32'(vin_i - vout_set_reg) * 32'(vout_set_reg)) / (32'(vin_i) * 32'(freq_i)));
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      peak_limit_o <= 16'h0000;
    end else begin
      peak_limit_o <= oc_limit_reg + (ripple >> 1);
    end
  end

  logic [2:0] oc_cnt_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_cnt_reg <= 3'h0;
    end else if (state_reg != FSM_ST_ON) begin
      oc_cnt_reg <= 3'h0;
    end else if (cyc_rise) begin
      oc_cnt_reg <= pk_s[1] ? ((oc_cnt_reg == FSM_OC_COUNT) ? oc_cnt_reg : oc_cnt_reg + 3'h1)
                            : 3'h0;
    end
  end
  wire running = state_reg == FSM_ST_ON;
  wire f_peak = running && oc_cnt_reg == FSM_OC_COUNT;
  wire f_avg = running && iout_i > oc_limit_reg;
  wire f_ot = running && temp_int_i > ot_limit_reg;
  wire f_grp = running && seq_reg[FSM_SQ_HONOR_BIT] && gb_s[1];
  wire own_fault = f_peak | f_avg | f_ot;
  wire any_fault = own_fault | f_grp;

  // set wins over clear; restart also clears
  wire restart_ok = state_reg == FSM_ST_RETRY && state_next == FSM_ST_OFF;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= ((clear_cmd || restart_ok) ? '0 : status_reg)
                  | {restore_cmd & ~restore_ok, f_grp, f_ot, f_avg, f_peak};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap_stat_reg <= 32'h0000_0000;
      snap_iout_reg <= 32'h0000_0000;
      snap_temp_reg <= 32'h0000_0000;
      snap_vout_reg <= 32'h0000_0000;
    end else if (any_fault) begin
      snap_stat_reg <= 32'({f_grp, f_ot, f_avg, f_peak});
      snap_iout_reg <= {16'h0000, iout_i};
      snap_temp_reg <= {temp_ext_i, temp_int_i};
      snap_vout_reg <= {vin_i, vout_i};
    end
  end

  // ----------------------------------------
  // sequencing state machine
  // ----------------------------------------
  logic [15:0] dly_reg;
  wire want_retry = (status_reg[FSM_ST_OT] & retry_reg[FSM_RT_OT_EN])
                  | ((status_reg[FSM_ST_OC_PEAK] | status_reg[FSM_ST_OC_AVG])
                     & retry_reg[FSM_RT_OC_EN]) | status_reg[FSM_ST_GROUP];
  wire prev_ok = seq_reg[FSM_SQ_FIRST_BIT] | pd_s[1];
  wire next_ok = seq_reg[FSM_SQ_LAST_BIT] | ~nd_s[1];
  wire cool = temp_int_i + FSM_OT_HYST <= ot_limit_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FSM_ST_INIT: if (!nv_busy_reg && !(init_go && nv_valid)) state_next = FSM_ST_OFF;
      FSM_ST_OFF: if (en_s[1]) state_next = FSM_ST_WAIT_PREV;
      FSM_ST_WAIT_PREV: begin
        if (!en_s[1]) state_next = FSM_ST_OFF;
        else if (prev_ok) state_next = FSM_ST_ON;
      end
      FSM_ST_ON: begin
        if (any_fault) state_next = FSM_ST_FAULT;
        else if (!en_s[1]) state_next = FSM_ST_WAIT_NEXT;
      end
      FSM_ST_WAIT_NEXT: begin
        if (next_ok) state_next = FSM_ST_OFF;
        else if (en_s[1]) state_next = FSM_ST_ON;
      end
      FSM_ST_FAULT: begin
        if (want_retry) state_next = FSM_ST_RETRY;
        // without retry only dropping the shared enable leaves the latch-off
        else if (!en_s[1]) state_next = FSM_ST_OFF;
      end
      FSM_ST_RETRY: begin
        if (dly_reg == 16'h0000 && (cool || !status_reg[FSM_ST_OT])) begin
          state_next = FSM_ST_OFF;
        end
      end
      default: state_next = FSM_ST_INIT;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= FSM_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_reg <= 16'h0000;
    end else if (state_reg == FSM_ST_FAULT) begin
      dly_reg <= retry_reg[FSM_RT_DLY_LSB +: FSM_RT_DLY_W];
    end else if (state_reg == FSM_ST_RETRY) begin
      if (dly_reg != 16'h0000) begin
        dly_reg <= dly_reg - 16'h0001;
      end else if (!cool && status_reg[FSM_ST_OT]) begin
        dly_reg <= retry_reg[FSM_RT_DLY_LSB +: FSM_RT_DLY_W];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_on_o <= 1'b0;
      seq_done_o <= 1'b0;
      group_bus_o <= 1'b0;
      group_bus_oe_o <= 1'b0;
    end else begin
      power_on_o <= state_next == FSM_ST_ON || state_next == FSM_ST_WAIT_NEXT;
      seq_done_o <= state_next == FSM_ST_ON;
      // open drain: drive low never, assert fault by driving high pulse
      group_bus_o <= state_reg == FSM_ST_ON && own_fault && seq_reg[FSM_SQ_BCAST_BIT];
      group_bus_oe_o <= state_reg == FSM_ST_ON && own_fault
                      && seq_reg[FSM_SQ_BCAST_BIT];
    end
  end

  // ----------------------------------------
  // phase offset against shared clock
  // ----------------------------------------
  // sixteen sub-slots per sync period; meaningless without common sync
  logic [15:0] per_cnt_reg, per_len_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_cnt_reg <= 16'h0000;
      per_len_reg <= 16'h0000;
    end else if (sync_rise) begin
      per_len_reg <= per_cnt_reg;
      per_cnt_reg <= 16'h0000;
    end else begin
      per_cnt_reg <= per_cnt_reg + 16'h0001;
    end
  end
  wire [19:0] ofs_prod = 20'(per_len_reg) * 20'(phase_reg);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_start_o <= 1'b0;
    end else begin
      phase_start_o <= per_cnt_reg == ofs_prod[19:4];
    end
  end

  // ----------------------------------------
  // apb slave: no wait states
  // ----------------------------------------
  logic [31:0] rd;
  logic hit;
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr_i)
      FSM_CTRL_OFS: rd = 32'h0000_0000;
      FSM_STATUS_OFS: rd = {16'h0000, 2'h0, state_reg, 2'h0, status_reg};
      FSM_OC_LIMIT_OFS: rd = {16'h0000, oc_limit_reg};
      FSM_OT_LIMIT_OFS: rd = {16'h0000, ot_limit_reg};
      FSM_RETRY_OFS: rd = retry_reg;
      FSM_PHASE_OFS: rd = {28'h0000000, phase_reg};
      FSM_SEQ_OFS: rd = seq_reg;
      FSM_VOUT_SET_OFS: rd = {16'h0000, vout_set_reg};
      FSM_VIN_OFS: rd = {16'h0000, vin_i};
      FSM_VOUT_OFS: rd = {16'h0000, vout_i};
      FSM_IOUT_OFS: rd = {16'h0000, iout_i};
      FSM_TINT_OFS: rd = {16'h0000, temp_int_i};
      FSM_TEXT_OFS: rd = {16'h0000, temp_ext_i};
      FSM_DUTY_OFS: rd = {16'h0000, duty_i};
      FSM_FREQ_OFS: rd = {16'h0000, freq_i};
      FSM_VMON_OFS: rd = {16'h0000, vmon_i};
      FSM_SNAP_STAT_OFS: rd = snap_stat_reg;
      FSM_SNAP_IOUT_OFS: rd = snap_iout_reg;
      FSM_SNAP_TEMP_OFS: rd = snap_temp_reg;
      FSM_SNAP_VOUT_OFS: rd = snap_vout_reg;
      FSM_GRANT_OFS: rd = {30'h00000000, grant_reg};
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~hit;
      prdata_o <= (setup && !pwrite_i) ? rd : 32'h0000_0000;
    end
  end
endmodule : fault_sequence_manager

// ==== verilog/fsm_nvm.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// nonvolatile configuration store
// ----------------------------------------
module fsm_nvm
  import fsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic valid_o
);
  logic [31:0] mem [FSM_NV_WORDS];
  logic [7:0] tag_reg;

  // array holds no reset; the tag marks contents as stored
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tag_reg <= 8'h00;
    end else if (wr_i) begin
      tag_reg <= FSM_NV_VALID;
    end
  end

  assign rdata_o = mem[addr_i];
  assign valid_o = (tag_reg == FSM_NV_VALID);
endmodule : fsm_nvm

// ==== verilog/fsm_pkg.sv ====
package fsm_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] FSM_CTRL_OFS = 8'h00;
  localparam logic [7:0] FSM_STATUS_OFS = 8'h04;
  localparam logic [7:0] FSM_OC_LIMIT_OFS = 8'h08;
  localparam logic [7:0] FSM_OT_LIMIT_OFS = 8'h0c;
  localparam logic [7:0] FSM_RETRY_OFS = 8'h10;
  localparam logic [7:0] FSM_PHASE_OFS = 8'h14;
  localparam logic [7:0] FSM_SEQ_OFS = 8'h18;
  localparam logic [7:0] FSM_VOUT_SET_OFS = 8'h1c;
  localparam logic [7:0] FSM_VIN_OFS = 8'h20;
  localparam logic [7:0] FSM_VOUT_OFS = 8'h24;
  localparam logic [7:0] FSM_IOUT_OFS = 8'h28;
  localparam logic [7:0] FSM_TINT_OFS = 8'h2c;
  localparam logic [7:0] FSM_TEXT_OFS = 8'h30;
  localparam logic [7:0] FSM_DUTY_OFS = 8'h34;
  localparam logic [7:0] FSM_FREQ_OFS = 8'h38;
  localparam logic [7:0] FSM_VMON_OFS = 8'h3c;
  localparam logic [7:0] FSM_SNAP_STAT_OFS = 8'h40;
  localparam logic [7:0] FSM_SNAP_IOUT_OFS = 8'h44;
  localparam logic [7:0] FSM_SNAP_TEMP_OFS = 8'h48;
  localparam logic [7:0] FSM_SNAP_VOUT_OFS = 8'h4c;
  localparam logic [7:0] FSM_GRANT_OFS = 8'h50;
  // ----------------------------------------
  // control register bits (write 1 pulses)
  // ----------------------------------------
  localparam int FSM_CTRL_CLEAR_BIT = 0;
  localparam int FSM_CTRL_STORE_BIT = 1;
  localparam int FSM_CTRL_RESTORE_BIT = 2;
  // status bits
  localparam int FSM_ST_OC_PEAK = 0;
  localparam int FSM_ST_OC_AVG = 1;
  localparam int FSM_ST_OT = 2;
  localparam int FSM_ST_GROUP = 3;
  localparam int FSM_ST_DENIED = 4;
  localparam int FSM_ST_FLAGS = 5;
  // retry register fields
  localparam int FSM_RT_OC_EN = 0;
  localparam int FSM_RT_OT_EN = 1;
  localparam int FSM_RT_DLY_LSB = 8;
  localparam int FSM_RT_DLY_W = 16;
  // sequence register fields
  localparam int FSM_SQ_PREV_LSB = 0;
  localparam int FSM_SQ_NEXT_LSB = 5;
  localparam int FSM_SQ_ID_W = 5;
  localparam int FSM_SQ_BCAST_BIT = 10;
  localparam int FSM_SQ_HONOR_BIT = 11;
  localparam int FSM_SQ_FIRST_BIT = 12;
  localparam int FSM_SQ_LAST_BIT = 13;
  // ----------------------------------------
  // reset values and fixed figures
  // ----------------------------------------
  localparam logic [15:0] FSM_OT_LIMIT_RST = 16'h007d;
  localparam logic [15:0] FSM_OT_HYST = 16'h000f;
  localparam logic [15:0] FSM_OC_LIMIT_RST = 16'hffff;
  localparam logic [2:0] FSM_OC_COUNT = 3'h5;
  localparam logic [3:0] FSM_PHASE_STEPS = 4'hf;
  localparam logic [1:0] FSM_LEVEL_FACTORY = 2'h0;
  localparam logic [1:0] FSM_LEVEL_USER = 2'h1;
  localparam int FSM_NV_WORDS = 8;
  localparam logic [7:0] FSM_NV_VALID = 8'ha5;
  // ----------------------------------------
  // main state machine
  // ----------------------------------------
  typedef enum logic [6:0] {
    FSM_ST_INIT = 7'h01,
    FSM_ST_OFF = 7'h02,
    FSM_ST_WAIT_PREV = 7'h04,
    FSM_ST_ON = 7'h08,
    FSM_ST_WAIT_NEXT = 7'h10,
    FSM_ST_FAULT = 7'h20,
    FSM_ST_RETRY = 7'h40
  } fsm_state_t;
endpackage : fsm_pkg
